// *** framer_regs.svh ***
`ifndef FRAMER_REGS_SVH
`define FRAMER_REGS_SVH
// register byte offsets
`define CTRL_OFS 12'h000
`define SYNC_OFS 12'h004
`define DIV_OFS 12'h008
`define TXD_OFS 12'h00C
`define RXD_OFS 12'h010
`define STAT_OFS 12'h014
// reset values
`define CTRL_RST 12'h002
`define SYNC_RST 16'h1616
`define DIV_RST 16'h0081
// status field positions
`define ST_TXF 0
`define ST_RXF 1
`define ST_PERR 2
`define ST_FERR 3
`define ST_OVR 4
`define ST_HUNT 5
// sampling pulses per bit
`define OSR_ISO 7'h01
`define OSR_16 7'h10
`define OSR_64 7'h40
`endif

// *** framer_pkg.sv ***
`include "framer_regs.svh"
package framer_pkg;
    typedef enum logic [1:0] {M_SYNC = 2'b00, M_ISO = 2'b01, M_A16 = 2'b10, M_A64 = 2'b11} mode_e;
    typedef enum logic [1:0] {T_IDLE = 2'b00, T_START = 2'b01, T_BITS = 2'b10,
                              T_STOP = 2'b11} tx_state_e;
    typedef enum logic [2:0] {R_IDLE = 3'b000, R_HUNT = 3'b001, R_START = 3'b010,
                              R_BITS = 3'b011, R_STOP = 3'b100} rx_state_e;
    typedef struct packed {
        logic tx_en;
        logic rx_en;
        logic discard;
        logic dsync;
        logic [1:0] stop;
        logic par_odd;
        logic par_en;
        logic [1:0] len;
        mode_e mode;
    } cfg_s;
    function automatic logic [6:0] osr_f(input mode_e m);
        unique case (m)
            M_A16: osr_f = `OSR_16;
            M_A64: osr_f = `OSR_64;
            default: osr_f = `OSR_ISO;
        endcase
    endfunction : osr_f
    function automatic logic [3:0] nbits_f(input cfg_s c);
        nbits_f = {2'b00, c.len} + 4'd5 + {3'b000, c.par_en && c.mode != M_SYNC};
    endfunction : nbits_f
endpackage : framer_pkg

// *** framer_if.sv ***
`timescale 1ns/10ps
`default_nettype none
interface framer_if
    import framer_pkg::*;
();
    cfg_s cfg;
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [15:0] div;
    logic tick;
    logic tx_valid;
    logic [7:0] tx_data;
    logic tx_take;
    logic txd;
    modport ctl (output cfg, sync1, sync2, div, tx_valid, tx_data, input tick, tx_take, txd);
    modport gen (input div, output tick);
    modport tx (input cfg, sync1, sync2, tick, tx_valid, tx_data, output tx_take, txd);
endinterface : framer_if
`default_nettype wire

// *** tick_divider.sv ***
`timescale 1ns/10ps
`default_nettype none
module tick_divider
    import framer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // carrier
    framer_if.gen fi
);
    typedef struct packed {logic [15:0] cnt; logic tick;} div_s;
    div_s s_q;
    div_s s_d;

    // sampling-rate enable, one pulse every div+1 cycles
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (s_q.cnt >= fi.div) begin
            s_d.cnt = 16'h0000;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s_q <= '0;
        else s_q <= s_d;
    end
    assign fi.tick = s_q.tick;
endmodule : tick_divider
`default_nettype wire

// *** serial_tx.sv ***
`timescale 1ns/10ps
`default_nettype none
module serial_tx
    import framer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // carrier
    framer_if.tx fi
);
    typedef struct packed {
        tx_state_e st;
        logic [7:0] cnt;
        logic [3:0] bc;
        logic [8:0] sh;
        logic txd;
        logic take;
        logic phase;
        logic lead;
    } tx_s;
    tx_s s_q;
    tx_s s_d;
    logic [7:0] osr;
    logic [7:0] stop_len;
    logic [7:0] msk;
    logic [8:0] ch;
    logic sy;
    logic ld;

    always_comb begin
        s_d = s_q;
        s_d.take = 1'b0;
        osr = {1'b0, osr_f(fi.cfg.mode)};
        sy = fi.cfg.mode == M_SYNC;
        msk = 8'hFF >> (2'd3 - fi.cfg.len);
        unique case (fi.cfg.stop)
            2'b00: stop_len = osr;
            2'b01: stop_len = osr + (osr >> 1);
            default: stop_len = osr << 1;
        endcase
        ld = 1'b0;
        ch = {1'b0, fi.tx_data & msk};
        ch = ch | (9'({(^(fi.tx_data & msk)) ^ fi.cfg.par_odd, 8'h00}) >> (2'd3 - fi.cfg.len));
        if (!fi.cfg.tx_en) begin
            s_d.st = T_IDLE;
            s_d.txd = 1'b1;
            s_d.lead = 1'b1;
            s_d.phase = 1'b0;
        end else if (fi.tick) begin
            s_d.cnt = s_q.cnt + 8'h01;
            unique case (s_q.st)
                T_IDLE: ld = 1'b1;
                T_START: if (s_q.cnt == osr - 8'h01) begin
                    s_d.st = T_BITS;
                    s_d.cnt = 8'h00;
                    s_d.txd = s_q.sh[0];
                    s_d.sh = s_q.sh >> 1;
                end
                T_BITS: if (s_q.cnt == osr - 8'h01) begin
                    s_d.cnt = 8'h00;
                    if (s_q.bc == nbits_f(fi.cfg) - 4'd1) begin
                        ld = sy;
                        if (!sy) s_d.st = T_STOP;
                        s_d.txd = 1'b1;
                    end else begin
                        s_d.txd = s_q.sh[0];
                        s_d.sh = s_q.sh >> 1;
                        s_d.bc = s_q.bc + 4'd1;
                    end
                end
                T_STOP: if (s_q.cnt == stop_len - 8'h01) ld = 1'b1;
            endcase
        end
        if (ld) begin
            s_d.cnt = 8'h00;
            s_d.bc = 4'd0;
            if (sy) begin
                if (fi.tx_valid && !s_q.lead && !s_q.phase) begin
                    s_d.take = 1'b1;
                end else begin
                    ch = {1'b0, s_q.phase ? fi.sync2 : fi.sync1};
                    s_d.lead = s_q.lead && fi.cfg.dsync && !s_q.phase;
                    s_d.phase = fi.cfg.dsync && !s_q.phase;
                end
                s_d.st = T_BITS;
                s_d.txd = ch[0];
                s_d.sh = ch >> 1;
            end else if (fi.tx_valid) begin
                s_d.take = 1'b1;
                s_d.st = T_START;
                s_d.txd = 1'b0;
                s_d.sh = ch;
            end else begin
                s_d.st = T_IDLE;
                s_d.txd = 1'b1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) s_q <= {T_IDLE, 8'h00, 4'd0, 9'h000, 1'b1, 1'b0, 1'b0, 1'b1};
        else s_q <= s_d;
    end
    assign fi.txd = s_q.txd;
    assign fi.tx_take = s_q.take;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_idle_high;
        (s_q.st == T_IDLE && fi.cfg.mode != M_SYNC) |-> s_q.txd;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("line not idle high");
    property p_start_low;
        (s_q.st == T_START) |-> !s_q.txd ##1 (s_q.st != T_START || !s_q.txd);
    endproperty
    a_start_low: assert property (p_start_low) else $error("start bit not low");
    property p_stop_high;
        $rose(s_q.st == T_STOP) |-> s_q.txd && $past(s_q.st) == T_BITS;
    endproperty
    a_stop_high: assert property (p_stop_high) else $error("stop bit not high");
endmodule : serial_tx
`default_nettype wire

// *** serial_framer.sv ***
// The register addresses and the APB slave port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "framer_regs.svh"
module serial_framer
    import framer_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // serial line
    input wire logic rxd,
    output logic txd
);
    typedef struct packed {
        cfg_s cfg;
        logic [7:0] s1;
        logic [7:0] s2;
        logic [15:0] div;
        logic [7:0] txh;
        logic txf;
        logic [7:0] rxh;
        logic rxf;
        logic perr;
        logic ferr;
        logic ovr;
        logic rdy;
        logic err;
        logic [31:0] rdat;
        rx_state_e st;
        logic [6:0] cnt;
        logic [3:0] bc;
        logic [8:0] sh;
        logic [15:0] hist;
        logic prev;
    } top_s;
    top_s s_q;
    top_s s_d;

    framer_if fi ();
    tick_divider u_div (
        .pclk(pclk),
        .presetn(presetn),
        .fi(fi.gen)
    );
    serial_tx u_tx (
        .pclk(pclk),
        .presetn(presetn),
        .fi(fi.tx)
    );
    assign fi.cfg = s_q.cfg;
    assign fi.sync1 = s_q.s1;
    assign fi.sync2 = s_q.s2;
    assign fi.div = s_q.div;
    assign fi.tx_valid = s_q.txf;
    assign fi.tx_data = s_q.txh;

    // --------------------------------------------------------------
    // character helpers
    // --------------------------------------------------------------
    function automatic logic match_f(input logic [15:0] h, input cfg_s c,
                                     input logic [7:0] a, input logic [7:0] b);
        logic [3:0] l;
        logic [7:0] m;
        logic [15:0] w;
        logic [15:0] w2;
        l = {2'b00, c.len} + 4'd5;
        m = 8'hFF >> (2'd3 - c.len);
        w = c.dsync ? h >> (5'd16 - {l, 1'b0}) : h >> (5'd16 - {1'b0, l});
        w2 = w >> l;
        match_f = (w[7:0] & m) == (a & m) && (!c.dsync || (w2[7:0] & m) == (b & m));
    endfunction : match_f

    logic acc;
    logic done;
    logic sy;
    logic dv;
    logic pe;
    logic fe;
    logic hit;
    logic [6:0] osr;
    logic [3:0] nb;
    logic [7:0] msk;
    logic [8:0] w9;
    logic [7:0] dch;
    logic [15:0] hn;

    // --------------------------------------------------------------
    // registers, apb and receiver
    // --------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        acc = psel && penable;
        done = acc && s_q.rdy;
        sy = s_q.cfg.mode == M_SYNC;
        osr = osr_f(s_q.cfg.mode);
        nb = nbits_f(s_q.cfg);
        msk = 8'hFF >> (2'd3 - s_q.cfg.len);
        hn = {rxd, s_q.hist[15:1]};
        hit = match_f(hn, s_q.cfg, s_q.s1, s_q.s2);
        dv = 1'b0;
        fe = 1'b0;
        s_d.prev = rxd;
        if (fi.tx_take) s_d.txf = 1'b0;
        // one wait state: answer prepared, then completed
        if (acc && !s_q.rdy) begin
            s_d.rdy = 1'b1;
            s_d.err = 1'b0;
            s_d.rdat = 32'h0000_0000;
            unique case (paddr)
                `CTRL_OFS: s_d.rdat = {20'h00000, s_q.cfg};
                `SYNC_OFS: s_d.rdat = {16'h0000, s_q.s2, s_q.s1};
                `DIV_OFS: s_d.rdat = {16'h0000, s_q.div};
                `TXD_OFS: s_d.rdat = {24'h000000, s_q.txh};
                `RXD_OFS: s_d.rdat = {24'h000000, s_q.rxh};
                `STAT_OFS: s_d.rdat = {26'h0000000, s_q.st == R_HUNT, s_q.ovr, s_q.ferr,
                                       s_q.perr, s_q.rxf, s_q.txf};
                default: s_d.err = 1'b1;
            endcase
        end
        if (done) begin
            s_d.rdy = 1'b0;
            s_d.err = 1'b0;
            s_d.rdat = 32'h0000_0000;
            if (pwrite) begin
                unique case (paddr)
                    `CTRL_OFS: s_d.cfg = cfg_s'(pwdata[11:0]);
                    `SYNC_OFS: {s_d.s2, s_d.s1} = pwdata[15:0];
                    `DIV_OFS: s_d.div = pwdata[15:0];
                    `TXD_OFS: begin
                        s_d.txh = pwdata[7:0];
                        s_d.txf = 1'b1;
                    end
                    `STAT_OFS: begin
                        s_d.perr = s_q.perr & ~pwdata[`ST_PERR];
                        s_d.ferr = s_q.ferr & ~pwdata[`ST_FERR];
                        s_d.ovr = s_q.ovr & ~pwdata[`ST_OVR];
                    end
                    default: s_d.err = 1'b0;
                endcase
            end else if (paddr == `RXD_OFS) begin
                s_d.rxf = 1'b0;
            end
        end
        // receiver
        if (!s_q.cfg.rx_en) begin
            s_d.st = sy ? R_HUNT : R_IDLE;
            s_d.cnt = 7'h00;
        end else begin
            unique case (s_q.st)
                R_IDLE: begin
                    if (sy) begin
                        s_d.st = R_HUNT;
                    end else if (s_q.cfg.mode == M_ISO) begin
                        if (fi.tick && !rxd) begin
                            s_d.st = R_BITS;
                            s_d.cnt = 7'h00;
                            s_d.bc = 4'd0;
                        end
                    end else if (s_q.prev && !rxd) begin
                        s_d.st = R_START;
                        s_d.cnt = 7'h00;
                    end
                end
                R_HUNT: begin
                    if (!sy) begin
                        s_d.st = R_IDLE;
                    end else if (fi.tick) begin
                        s_d.hist = hn;
                        if (hit) begin
                            s_d.st = R_BITS;
                            s_d.cnt = 7'h00;
                            s_d.bc = 4'd0;
                        end
                    end
                end
                R_START: begin
                    // free-running ticks: phase error below one pulse
                    if (fi.tick) begin
                        s_d.cnt = s_q.cnt + 7'h01;
                        if (s_q.cnt == (osr >> 1) - 7'h01) begin
                            s_d.cnt = 7'h00;
                            s_d.bc = 4'd0;
                            s_d.st = rxd ? R_IDLE : R_BITS;
                        end
                    end
                end
                R_BITS: begin
                    if (fi.tick) begin
                        s_d.cnt = s_q.cnt + 7'h01;
                        if (s_q.cnt == osr - 7'h01) begin
                            s_d.cnt = 7'h00;
                            s_d.sh = {rxd, s_q.sh[8:1]};
                            s_d.bc = s_q.bc + 4'd1;
                            if (s_q.bc == nb - 4'd1) begin
                                s_d.bc = 4'd0;
                                dv = sy;
                                if (!sy) s_d.st = R_STOP;
                            end
                        end
                    end
                end
                R_STOP: begin
                    if (fi.tick) begin
                        s_d.cnt = s_q.cnt + 7'h01;
                        if (s_q.cnt == osr - 7'h01) begin
                            dv = 1'b1;
                            fe = !rxd;
                            s_d.st = R_IDLE;
                        end
                    end
                end
                default: s_d.st = R_IDLE;
            endcase
        end
        // assemble and hand over the received character
        w9 = s_d.sh >> (4'd9 - nb);
        dch = w9[7:0] & msk;
        pe = s_q.cfg.par_en && !sy && ((^dch) ^ w9[{2'b00, s_q.cfg.len} + 4'd5] ^ s_q.cfg.par_odd);
        if (dv && sy && s_q.cfg.discard) begin
            if (dch == (s_q.s1 & msk) || (s_q.cfg.dsync && dch == (s_q.s2 & msk))) begin
                dv = 1'b0;
            end
        end
        if (dv) begin
            s_d.rxh = dch;
            if (s_d.rxf) s_d.ovr = 1'b1;
            s_d.rxf = 1'b1;
            if (pe) s_d.perr = 1'b1;
            if (fe) s_d.ferr = 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
            s_q.cfg <= cfg_s'(`CTRL_RST);
            s_q.s1 <= 8'(`SYNC_RST);
            s_q.s2 <= 8'(`SYNC_RST >> 8);
            s_q.div <= `DIV_RST;
            s_q.prev <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdat;
    assign pready = s_q.rdy;
    assign pslverr = s_q.err;
    assign txd = fi.txd;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_edge;
        s_q.st == R_IDLE && s_q.cfg.rx_en && s_q.cfg.mode[1] && s_q.prev && !rxd;
    endsequence
    property p_start_arm;
        s_edge |=> s_q.st == R_START && s_q.cnt == 7'h00;
    endproperty
    a_start_arm: assert property (p_start_arm) else $error("start not armed");
    property p_start_check;
        (s_q.st == R_START && s_q.cfg.rx_en && fi.tick && s_q.cnt == (osr >> 1) - 7'h01)
            |=> s_q.st == ($past(rxd) ? R_IDLE : R_BITS);
    endproperty
    a_start_check: assert property (p_start_check) else $error("start check wrong");
    property p_bit_step;
        (s_q.st == R_BITS && s_q.cfg.rx_en && fi.tick && s_q.cnt == osr - 7'h01
            && s_q.bc != nb - 4'd1) |=> s_q.bc == $past(s_q.bc) + 4'd1 && s_q.cnt == 7'h00;
    endproperty
    a_bit_step: assert property (p_bit_step) else $error("bit step wrong");
    property p_frame_err;
        (s_q.st == R_STOP && s_q.cfg.rx_en && fi.tick && s_q.cnt == osr - 7'h01 && !rxd)
            |=> s_q.ferr && s_q.rxf && s_q.st == R_IDLE;
    endproperty
    a_frame_err: assert property (p_frame_err) else $error("framing error missed");
    property p_overrun;
        (dv && s_q.rxf && !(done && !pwrite && paddr == `RXD_OFS)) |=> s_q.ovr;
    endproperty
    a_overrun: assert property (p_overrun) else $error("overrun missed");
    property p_parity;
        (dv && pe) |=> s_q.perr && s_q.rxh == $past(dch);
    endproperty
    a_parity: assert property (p_parity) else $error("parity error missed");
    property p_hunt_lock;
        (s_q.st == R_HUNT && s_q.cfg.rx_en && sy && fi.tick && hit)
            |=> s_q.st == R_BITS && s_q.bc == 4'd0;
    endproperty
    a_hunt_lock: assert property (p_hunt_lock) else $error("sync lock missed");
    property p_apb_answer;
        (acc && !s_q.rdy) |=> s_q.rdy ##1 !s_q.rdy;
    endproperty
    a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing");
endmodule : serial_framer
`default_nettype wire

// *** line_partner.sv ***
`timescale 1ns/10ps
`default_nettype none
module line_partner (
    // clock
    input wire logic pclk,
    // serial line
    input wire logic txd,
    output logic rxd
);
    // ----
    // far end of the line
    // ----
    initial rxd = 1'h1;
    // frame goes out lsb first, whole cycles per bit
    task automatic send(input logic [31:0] f, input int n, input int bc);
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            rxd <= f[i];
            repeat (bc - 1) @(posedge pclk);
        end
        @(posedge pclk);
        rxd <= 1'h1;
    endtask : send
    // low pulse too short for a start bit
    task automatic glitch(input int n);
        @(posedge pclk);
        rxd <= 1'h0;
        repeat (n) @(posedge pclk);
        rxd <= 1'h1;
    endtask : glitch
    // waits for a start edge, then samples n bits at mid-bit
    task automatic recv(input int n, input int bc, output logic [31:0] f);
        int w;
        f = 32'h0;
        w = 0;
        @(posedge pclk);
        while (txd !== 1'h0 && w < 4000) begin
            @(posedge pclk);
            w++;
        end
        repeat (bc / 2) @(posedge pclk);
        for (int i = 0; i < n; i++) begin
            if (i > 0) repeat (bc) @(posedge pclk);
            f[i] = txd;
        end
    endtask : recv
endmodule : line_partner
`default_nettype wire

// *** test_sync_async_serial_framer.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "framer_regs.svh"
module test_sync_async_serial_framer;
    // ----
    // bench
    // ----
    logic pclk;
    logic presetn;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic rxd;
    logic txd;
    logic [31:0] rd;
    logic [31:0] fr;
    logic [31:0] ex;
    logic err;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    serial_framer DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .rxd(rxd), .txd(txd));
    line_partner far_end (.pclk(pclk), .txd(txd), .rxd(rxd));
    initial begin
        pclk = 1'h0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            stop_test();
        end
    end
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int w;
        w = 0;
        @(posedge pclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            w++;
        end while (pready !== 1'h1 && w < 50);
        if (pready !== 1'h1) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'h0, a, 32'h0);
        chk(rd, exp);
    endtask : rdchk
    // write while the far end captures the frame that follows
    task automatic txchk(input logic [11:0] a, input logic [31:0] d, input int n,
                         input int bc, input logic [31:0] exp);
        fork
            apb(1'h1, a, d);
            far_end.recv(n, bc, fr);
        join
        chk(fr, exp);
    endtask : txchk
    // ----
    // tests
    // ----
    initial begin
        presetn = 1'h0;
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 12'h0;
        pwdata = 32'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'h1;
        chk({31'h0, txd}, 32'h1);
        rdchk(`CTRL_OFS, 32'h002);
        rdchk(`SYNC_OFS, 32'h1616);
        rdchk(`DIV_OFS, 32'h0081);
        rdchk(`STAT_OFS, 32'h0);
        apb(1'h0, 12'h020, 32'h0);
        chk({rd[30:0], err}, 32'h1);
        apb(1'h1, `DIV_OFS, 32'h0);
        for (int l = 0; l < 4; l++) begin
            apb(1'h1, `CTRL_OFS, 32'hC02 | 32'(l << 2));
            ex = ((32'hD3 & ((32'h1 << (l + 5)) - 32'h1)) << 1) | (32'h1 << (l + 6));
            txchk(`TXD_OFS, 32'hD3, l + 7, 16, ex);
            repeat (16) @(posedge pclk);
        end
        far_end.send({22'h0, 1'h1, 8'h3C, 1'h0}, 10, 16);
        rdchk(`STAT_OFS, 32'h02);
        rdchk(`RXD_OFS, 32'h3C);
        far_end.glitch(5);
        repeat (200) @(posedge pclk);
        rdchk(`STAT_OFS, 32'h0);
        repeat (2) far_end.send({22'h0, 1'h1, 8'h81, 1'h0}, 10, 16);
        rdchk(`STAT_OFS, 32'h12);
        rdchk(`RXD_OFS, 32'h81);
        apb(1'h1, `STAT_OFS, 32'h1C);
        far_end.send({22'h0, 1'h0, 8'h55, 1'h0}, 10, 16);
        rdchk(`STAT_OFS, 32'h0A);
        repeat (200) @(posedge pclk);
        apb(1'h0, `RXD_OFS, 32'h0);
        apb(1'h1, `STAT_OFS, 32'h1C);
        apb(1'h1, `CTRL_OFS, 32'hCBA);
        txchk(`TXD_OFS, 32'h35, 11, 16, {21'h0, 2'h3, 1'h1, 7'h35, 1'h0});
        repeat (24) @(posedge pclk);
        far_end.send({21'h0, 2'h3, 1'h0, 7'h35, 1'h0}, 11, 16);
        rdchk(`STAT_OFS, 32'h06);
        rdchk(`RXD_OFS, 32'h35);
        apb(1'h1, `STAT_OFS, 32'h1C);
        apb(1'h1, `CTRL_OFS, 32'hC0F);
        txchk(`TXD_OFS, 32'hA5, 10, 64, {22'h0, 1'h1, 8'hA5, 1'h0});
        repeat (40) @(posedge pclk);
        far_end.send({22'h0, 1'h1, 8'h5A, 1'h0}, 10, 64);
        rdchk(`RXD_OFS, 32'h5A);
        apb(1'h1, `CTRL_OFS, 32'hC0D);
        txchk(`TXD_OFS, 32'h96, 10, 1, {22'h0, 1'h1, 8'h96, 1'h0});
        repeat (3) @(posedge pclk);
        far_end.send({22'h0, 1'h1, 8'hC6, 1'h0}, 10, 1);
        rdchk(`RXD_OFS, 32'hC6);
        apb(1'h1, `CTRL_OFS, 32'h40C);
        rdchk(`STAT_OFS, 32'h20);
        far_end.send({16'h0, 8'h5A, 8'h16}, 16, 1);
        rdchk(`RXD_OFS, 32'h5A);
        txchk(`CTRL_OFS, 32'h80C, 16, 1, 32'h1616);
        apb(1'h1, `CTRL_OFS, 32'h60C);
        apb(1'h0, `RXD_OFS, 32'h0);
        apb(1'h1, `STAT_OFS, 32'h1C);
        far_end.send({8'h0, 8'h5A, 8'h16, 8'h16}, 24, 1);
        rdchk(`STAT_OFS, 32'h02);
        stop_test();
    end
endmodule : test_sync_async_serial_framer
`default_nettype wire
